// file: common/raw_pkg.sv
// Constants for the slow-clock, alarm and watchdog control word.
// Assumes a synchronous 10 MHz core clock and an opcode command port.
package raw_pkg;
   // ****************************************
   // Clock
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   // ****************************************
   // Opcodes
   // ****************************************
   localparam logic [7:0] OPC_CTRL_WR = 8'h43;
   localparam logic [7:0] OPC_CTRL_RD = 8'hC3;
   localparam logic [7:0] OPC_STAT_RD = 8'hFE;
   // ****************************************
   // Control word fields
   // ****************************************
   localparam int CTRL_W = 16;
   localparam int BIT_WDOG_ENABLE = 0;
   localparam int BIT_WD_FLAG = 1;
   localparam int BIT_AM_LSB = 2;
   localparam int BIT_AM_MSB = 3;
   localparam int BIT_OSC_STOP_N = 4;
   localparam int BIT_CLK_OUT_EN = 5;
   localparam int BIT_BYPASS = 6;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WR_MASK = 16'h007D;
   // ****************************************
   // Interrupt status fields
   // ****************************************
   localparam int BIT_ALARM_FLAG = 14;
   // ****************************************
   // Alarm modes
   // ****************************************
   typedef enum logic [1:0] {
      AM_NONE,
      AM_MIN,
      AM_HOUR,
      AM_BOTH
   } raw_alarm_mode_t;
endpackage : raw_pkg

// file: src/raw_ctrl.sv
// Slow-clock source, alarm and watchdog control word with its opcode port.
// Assumes time-field increments, matches and the watchdog zero event come
// from the timekeeping logic outside, synchronous to i_clk.
`timescale 1ns/1ps
module raw_ctrl
   import raw_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_opcode,
   input wire logic [15:0] i_cmd_wdata,
   output logic o_rd_valid,
   output logic [15:0] o_rd_data,
   input wire logic i_int_enable,
   output logic o_int_n,
   input wire logic i_osc_clk,
   input wire logic i_slow_xtal_in_pin,
   output logic o_osc_run,
   output logic o_core_slow_clk,
   output logic o_slow_clock_out_pin_o,
   output logic o_slow_clock_out_pin_oe,
   input wire logic i_min_inc,
   input wire logic i_hour_inc,
   input wire logic i_min_match,
   input wire logic i_hour_match,
   input wire logic i_wdt_zero,
   output logic o_wdt_run,
   output logic o_watchdog_out_pin_o,
   output logic o_watchdog_out_pin_oe
);
   // ****************************************
   // Control word
   // ****************************************
   logic [15:0] ctrl_r;
   logic [15:0] ctrl_nxt;
   logic wr_ctrl;
   logic rd_ctrl;
   logic rd_stat;
   logic watchdog_flag;
   logic alarm_flag;
   logic wd_clr;
   logic wd_set;
   logic alarm_set;
   logic slow_clock_bypass;
   logic slow_clock_out_enable;
   logic osc_stop_n;
   logic watchdog_enable;
   raw_alarm_mode_t alarm_mode;

   assign wr_ctrl = i_cmd_valid && (i_cmd_opcode == OPC_CTRL_WR);
   assign rd_ctrl = i_cmd_valid && (i_cmd_opcode == OPC_CTRL_RD);
   assign rd_stat = i_cmd_valid && (i_cmd_opcode == OPC_STAT_RD);

   // Flag bit lives in its own sticky cell, so it is masked here
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = i_cmd_wdata & CTRL_WR_MASK;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_r <= CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   assign slow_clock_bypass = ctrl_r[BIT_BYPASS];
   assign slow_clock_out_enable = ctrl_r[BIT_CLK_OUT_EN];
   assign osc_stop_n = ctrl_r[BIT_OSC_STOP_N];
   assign watchdog_enable = ctrl_r[BIT_WDOG_ENABLE];
   assign alarm_mode = raw_alarm_mode_t'(ctrl_r[BIT_AM_MSB:BIT_AM_LSB]);

   // ****************************************
   // Slow clock source
   // ****************************************
   // External clock must keep running while bypassed
   assign o_osc_run = !osc_stop_n && !slow_clock_bypass;
   assign o_core_slow_clk = slow_clock_bypass ? i_slow_xtal_in_pin : i_osc_clk;

   logic clk_out_r;
   logic clk_out_nxt;

   // Registered copy keeps the pin glitch free across enable changes
   always_comb begin
      clk_out_nxt = slow_clock_out_enable && o_core_slow_clk;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         clk_out_r <= 1'b0;
      end else begin
         clk_out_r <= clk_out_nxt;
      end
   end

   assign o_slow_clock_out_pin_o = clk_out_r;
   assign o_slow_clock_out_pin_oe = slow_clock_out_enable;

   // ****************************************
   // Alarm
   // ****************************************
   always_comb begin
      case (alarm_mode)
         AM_MIN: alarm_set = i_min_inc && i_min_match;
         AM_HOUR: alarm_set = i_hour_inc && i_hour_match;
         AM_BOTH: alarm_set = (i_min_inc || i_hour_inc) && i_min_match && i_hour_match;
         default: alarm_set = 1'b0;
      endcase
   end

   raw_sticky_flag u_alarm_flag (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_set(alarm_set),
      .i_clr(rd_stat),
      .o_flag(alarm_flag)
   );

   assign o_int_n = !(alarm_flag && i_int_enable);

   // ****************************************
   // Watchdog
   // ****************************************
   assign o_wdt_run = watchdog_enable;
   assign wd_set = i_wdt_zero && watchdog_enable;
   assign wd_clr = wr_ctrl && !i_cmd_wdata[BIT_WD_FLAG];

   raw_sticky_flag u_wd_flag (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_set(wd_set),
      .i_clr(wd_clr),
      .o_flag(watchdog_flag)
   );

   // Open drain: only ever pulls low
   assign o_watchdog_out_pin_o = 1'b0;
   assign o_watchdog_out_pin_oe = watchdog_flag && watchdog_enable;

   // ****************************************
   // Read port
   // ****************************************
   logic rd_valid_r;
   logic rd_valid_nxt;
   logic [15:0] rd_data_r;
   logic [15:0] rd_data_nxt;

   always_comb begin
      rd_valid_nxt = rd_ctrl || rd_stat;
      rd_data_nxt = rd_data_r;
      if (rd_ctrl) begin
         rd_data_nxt = ctrl_r & CTRL_WR_MASK;
         rd_data_nxt[BIT_WD_FLAG] = watchdog_flag;
      end else if (rd_stat) begin
         rd_data_nxt = 16'h0000;
         rd_data_nxt[BIT_ALARM_FLAG] = alarm_flag;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rd_valid_r <= 1'b0;
         rd_data_r <= 16'h0000;
      end else begin
         rd_valid_r <= rd_valid_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   assign o_rd_valid = rd_valid_r;
   assign o_rd_data = rd_data_r;

   // ****************************************
   // Checks
   // ****************************************
   property p_bypass_stops_osc;
      @(posedge i_clk) disable iff (!i_rst_n)
      slow_clock_bypass |-> !o_osc_run && (o_core_slow_clk == i_slow_xtal_in_pin);
   endproperty
   a_bypass_stops_osc: assert property (p_bypass_stops_osc)
      else $error("Oscillator runs or wrong source in bypass");

   property p_clk_out_follow;
      @(posedge i_clk) disable iff (!i_rst_n)
      ##1 ($past(slow_clock_out_enable) && slow_clock_out_enable)
         |-> o_slow_clock_out_pin_o == $past(o_core_slow_clk);
   endproperty
   a_clk_out_follow: assert property (p_clk_out_follow)
      else $error("Slow clock out does not follow core clock");

   property p_osc_stop;
      @(posedge i_clk) disable iff (!i_rst_n)
      osc_stop_n |-> !o_osc_run;
   endproperty
   a_osc_stop: assert property (p_osc_stop)
      else $error("Oscillator runs while stopped");

   property p_no_alarm_mode;
      @(posedge i_clk) disable iff (!i_rst_n)
      (alarm_mode == AM_NONE) && !alarm_flag && !rd_stat |=> !alarm_flag;
   endproperty
   a_no_alarm_mode: assert property (p_no_alarm_mode)
      else $error("Alarm raised with mode none");

   property p_min_alarm;
      @(posedge i_clk) disable iff (!i_rst_n)
      (alarm_mode == AM_MIN) && i_min_inc && i_min_match |=> alarm_flag;
   endproperty
   a_min_alarm: assert property (p_min_alarm)
      else $error("Minute match did not set alarm flag");

   property p_int_held;
      @(posedge i_clk) disable iff (!i_rst_n)
      alarm_flag && i_int_enable && !rd_stat |=> !o_int_n || !i_int_enable;
   endproperty
   a_int_held: assert property (p_int_held)
      else $error("Interrupt dropped without status read");

   property p_wd_set;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_wdt_zero && watchdog_enable |=> watchdog_flag ##0 o_watchdog_out_pin_oe || !watchdog_enable;
   endproperty
   a_wd_set: assert property (p_wd_set)
      else $error("Watchdog zero did not set flag");

   property p_wd_sticky;
      @(posedge i_clk) disable iff (!i_rst_n)
      watchdog_flag && !wd_clr |=> watchdog_flag;
   endproperty
   a_wd_sticky: assert property (p_wd_sticky)
      else $error("Watchdog flag cleared on its own");

   property p_wd_release;
      @(posedge i_clk) disable iff (!i_rst_n)
      wd_clr && !wd_set |=> !o_watchdog_out_pin_oe;
   endproperty
   a_wd_release: assert property (p_wd_release)
      else $error("Watchdog pin not released after clear");

   property p_wd_disabled;
      @(posedge i_clk) disable iff (!i_rst_n)
      !watchdog_enable |-> !o_watchdog_out_pin_oe && !o_wdt_run;
   endproperty
   a_wd_disabled: assert property (p_wd_disabled)
      else $error("Watchdog active while disabled");

   property p_stat_read;
      @(posedge i_clk) disable iff (!i_rst_n)
      rd_stat |=> o_rd_valid && (o_rd_data[BIT_ALARM_FLAG] == $past(alarm_flag))
         && (o_rd_data[13:0] == 14'h0000);
   endproperty
   a_stat_read: assert property (p_stat_read)
      else $error("Status read data wrong");

   property p_ctrl_reserved;
      @(posedge i_clk) disable iff (!i_rst_n)
      rd_ctrl |=> o_rd_data[15:7] == 9'h000;
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved)
      else $error("Reserved bits read nonzero");

   c_alarm_both: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      (alarm_mode == AM_BOTH) && alarm_set);
   c_int_release: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      !o_int_n ##1 rd_stat ##1 o_int_n);
   c_wd_cycle: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      o_watchdog_out_pin_oe ##[1:20] !o_watchdog_out_pin_oe);
   c_bypass: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      slow_clock_bypass && slow_clock_out_enable);
endmodule : raw_ctrl

// file: src/raw_sticky_flag.sv
// Sticky event flag: set by hardware, cleared by a request.
// Assumes set and clear are one-cycle synchronous pulses.
`timescale 1ns/1ps
module raw_sticky_flag (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_set,
   input wire logic i_clr,
   output logic o_flag
);
   logic flag_r;
   logic flag_nxt;

   // Set wins so an event during a clear is kept
   always_comb begin
      flag_nxt = flag_r;
      if (i_clr) begin
         flag_nxt = 1'b0;
      end
      if (i_set) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign o_flag = flag_r;
endmodule : raw_sticky_flag

// file: tb/raw_host_model.sv
// Host model: command master and external slow clock source.
// Assumes the bench calls xfer hierarchically, one call at a time.
`timescale 1ns/1ps
module raw_host_model (
   input wire logic i_clk,
   input wire logic i_rd_valid,
   input wire logic [15:0] i_rd_data,
   output logic o_cmd_valid,
   output logic [7:0] o_cmd_opcode,
   output logic [15:0] o_cmd_wdata,
   output logic o_ext_clk
);
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_opcode = 8'h00;
      o_cmd_wdata = 16'h0000;
      o_ext_clk = 1'b0;
   end
   // *****
   // External clock, scaled down to keep runs short
   // *****
   always begin
      repeat (3) @(posedge i_clk);
      o_ext_clk <= ~o_ext_clk;
   end
   // *****
   // One command; idle lines show the inverse, not the old value
   // *****
   task automatic xfer(input logic [7:0] op, input logic [15:0] wd,
         output logic rv, output logic [15:0] rd);
      @(posedge i_clk);
      o_cmd_valid <= 1'b1;
      o_cmd_opcode <= op;
      o_cmd_wdata <= wd;
      @(posedge i_clk);
      o_cmd_valid <= 1'b0;
      o_cmd_opcode <= ~op;
      o_cmd_wdata <= ~wd;
      @(negedge i_clk);
      rv = i_rd_valid;
      rd = i_rd_data;
   endtask : xfer
endmodule : raw_host_model

// file: tb/test_raw_ctrl.sv
// Self-checking bench for the control word block.
// Assumes the host model drives commands and the external slow clock.
`timescale 1ns/1ps
module test_raw_ctrl
   import raw_pkg::*;
;
   logic clk, rst_n, int_en, osc, mi, hi, mm, hm, wz, prev;
   logic cv, rv, int_n, run, core, co_o, co_oe, wrun, wd_o, wd_oe, ext;
   logic [7:0] opc;
   logic [15:0] wdat, rdat;
   int bad_count = 0;
   int n_checks = 0;
   raw_host_model raw_host_model_i (.i_clk(clk), .i_rd_valid(rv), .i_rd_data(rdat),
      .o_cmd_valid(cv), .o_cmd_opcode(opc), .o_cmd_wdata(wdat), .o_ext_clk(ext));
   raw_ctrl raw_ctrl_i (.i_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(cv),
      .i_cmd_opcode(opc), .i_cmd_wdata(wdat), .o_rd_valid(rv), .o_rd_data(rdat),
      .i_int_enable(int_en), .o_int_n(int_n), .i_osc_clk(osc),
      .i_slow_xtal_in_pin(ext), .o_osc_run(run), .o_core_slow_clk(core),
      .o_slow_clock_out_pin_o(co_o), .o_slow_clock_out_pin_oe(co_oe),
      .i_min_inc(mi), .i_hour_inc(hi), .i_min_match(mm), .i_hour_match(hm),
      .i_wdt_zero(wz), .o_wdt_run(wrun), .o_watchdog_out_pin_o(wd_o),
      .o_watchdog_out_pin_oe(wd_oe));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always begin
      repeat (2) @(posedge clk);
      osc <= ~osc;
   end
   // *****
   // Helpers
   // *****
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] d);
      logic v;
      logic [15:0] r;
      raw_host_model_i.xfer(OPC_CTRL_WR, d, v, r);
   endtask : wr
   task automatic rdc(input logic [7:0] op, input logic [15:0] exp);
      logic v;
      logic [15:0] r;
      raw_host_model_i.xfer(op, 16'h0000, v, r);
      chk("rd_valid", v, 16'h0001);
      chk("rd_data", r, exp);
   endtask : rdc
   task automatic pulse(input logic a, b, c, d, e);
      @(posedge clk);
      {mi, hi, mm, hm, wz} <= {a, b, c, d, e};
      @(posedge clk);
      {mi, hi, mm, hm, wz} <= 5'h00;
      @(negedge clk);
   endtask : pulse
   // *****
   // Scenarios
   // *****
   task automatic t_clock();
      wr(16'hFFFF);
      rdc(OPC_CTRL_RD, 16'h007D);
      chk("co_oe", co_oe, 16'h0001);
      chk("wdt_run", wrun, 16'h0001);
      // Sample away from the launching edge; the pin copy lags one cycle
      @(negedge clk);
      prev = core;
      repeat (8) begin
         @(negedge clk);
         chk("core", core, ext);
         chk("co_o", co_o, prev);
         prev = core;
      end
      wr(16'h0040);
      chk("run", run, 16'h0000);
      wr(16'h0010);
      chk("run", run, 16'h0000);
      wr(16'h0000);
      chk("run", run, 16'h0001);
      repeat (6) @(negedge clk);
      chk("core", core, osc);
      chk("co_o", co_o | co_oe, 16'h0000);
      $display("test clock done");
   endtask : t_clock
   task automatic t_alarm();
      int m, k;
      logic f;
      for (int i = 0; i < 13; i++) begin
         m = (i == 12) ? 1 : i / 3;
         k = i % 3;
         // Hours mode needs an hours increment; a minutes step alone does not fire it
         f = (k == 0 && m == 1) || (k == 1 && m == 2) || (k == 2 && (m == 1 || m == 3));
         @(posedge clk);
         int_en <= (i != 12);
         wr(16'(m << 2));
         pulse(k != 1, k == 1, k != 1, k != 0, 1'b0);
         repeat (3) @(negedge clk);
         chk("int_n", int_n, !(f && i != 12));
         rdc(OPC_STAT_RD, f ? 16'h4000 : 16'h0000);
         chk("int_n", int_n, 16'h0001);
      end
      $display("test alarm done");
   endtask : t_alarm
   task automatic t_wdog();
      wr(16'h0001);
      pulse(0, 0, 0, 0, 1);
      chk("wd_oe", wd_oe, 16'h0001);
      chk("wd_o", wd_o, 16'h0000);
      rdc(OPC_CTRL_RD, 16'h0003);
      wr(16'h0003);
      repeat (20) @(negedge clk);
      chk("wd_oe", wd_oe, 16'h0001);
      wr(16'h0002);
      chk("wd_oe", wd_oe, 16'h0000);
      rdc(OPC_CTRL_RD, 16'h0002);
      wr(16'h0003);
      chk("wd_oe", wd_oe, 16'h0001);
      wr(16'h0001);
      chk("wd_oe", wd_oe, 16'h0000);
      wr(16'h0000);
      pulse(0, 0, 0, 0, 1);
      rdc(OPC_CTRL_RD, 16'h0000);
      $display("test watchdog done");
   endtask : t_wdog
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   // *****
   // Main sequence and watchdog
   // *****
   initial begin
      {rst_n, int_en, osc, mi, hi, mm, hm, wz} = 8'h00;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("int_n", int_n, 16'h0001);
      chk("wd_oe", wd_oe, 16'h0000);
      rdc(OPC_CTRL_RD, CTRL_RESET);
      t_clock();
      t_alarm();
      t_wdog();
      give_verdict();
   end
   initial begin
      #(CLK_PERIOD_NS * 5000);
      bad_count++;
      give_verdict();
   end
endmodule : test_raw_ctrl
